// File: design/adc_output_format.v
`timescale 1ns/1ps
`include "fmt_regs.vh"
// Overview of operation
// [RULE_01] XOR enable flips every bit by LSB
// [RULE_02] Code 0: two lanes, 20 bits each
// [RULE_03] Code 2: two lanes, 24 bits each
// [RULE_04] Code 5: first lane only, 20 bits
// [RULE_05] Code 7: first lane only, 24 bits
// [RULE_06] Pattern enable replaces first channel data
// [RULE_07] Select 0 or 1: fixed word zero
// [RULE_08] Select 2: ramp output
// [RULE_09] Select 3: alternate word zero and one
// [RULE_10] Ramp advances by step plus one
// [RULE_11] Word zero: low register plus split low
// [RULE_12] Word one: split high plus high register
// [RULE_13] Lane field bits 2-0, resets two
// [RULE_14] Software keeps reserved fields at reset
// [RULE_15] Ramp 24 bits, wraps, restarts on entry
// [RULE_16] Alternation starts with word zero
module adc_output_format
#(
	parameter DATA_W = 24
)
(
	input wire ref_clk,
	input wire sys_rst,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire [DATA_W-1:0] conv_data_ch1,
	input wire [DATA_W-1:0] conv_data_ch2,
	input wire conv_valid,
	output reg serial_out_first,
	output reg serial_out_second,
	output reg frame_sync,
	output reg busy
);
	// Registers
	reg [15:0] lane_cfg_q;
	reg [15:0] pat_ctrl_q;
	reg [15:0] pat0_low_q;
	reg [15:0] pat_split_q;
	reg [15:0] pat1_high_q;
	reg ack_q;
	reg [31:0] rd_d;
	reg hit;
	wire [5:0] reg_idx;
	wire access;
	wire [15:0] wmask;
	// Frame engine
	reg [47:0] sh1_q;
	reg [47:0] sh2_q;
	reg [5:0] cnt_q;
	reg [5:0] len_q;
	reg one_lane_q;
	reg [2:0] lanes_sel;
	reg [5:0] bits_sel;
	reg one_sel;
	reg overrun_q;
	wire [23:0] word0;
	wire [23:0] word1;
	wire [23:0] pattern_word;
	wire [23:0] ch1_src;
	wire [23:0] ch1_x;
	wire [23:0] ch2_x;
	wire [23:0] ch1_j;
	wire [23:0] ch2_j;
	wire [23:0] ch1_t;
	wire [23:0] ch2_t;
	wire start;
	// Per-register strobes
	wire wr_lane;
	wire wr_ctrl;
	wire wr_p0lo;
	wire wr_split;
	wire wr_p1hi;
	wire rd_status;

	assign reg_idx = avs_address[7:2];
	assign access = (avs_read | avs_write) & ~ack_q;
	assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	// Raised only on the taking edge, never on the answer edge
	assign wr_lane = access & avs_write & (reg_idx == `REG_LANE_CFG);
	assign wr_ctrl = access & avs_write & (reg_idx == `REG_PAT_CTRL);
	assign wr_p0lo = access & avs_write & (reg_idx == `REG_PAT0_LOW);
	assign wr_split = access & avs_write & (reg_idx == `REG_PAT_SPLIT);
	assign wr_p1hi = access & avs_write & (reg_idx == `REG_PAT1_HIGH);
	assign rd_status = access & avs_read & (reg_idx == `REG_STATUS);

	assign word0 = {pat_split_q[7:0], pat0_low_q}; // [RULE_11]
	assign word1 = {pat1_high_q, pat_split_q[15:8]}; // [RULE_12]

	pattern_gen u_pat
	(
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pattern_select_ch1(pat_ctrl_q[`PAT_SEL_HI:`PAT_SEL_LO]),
		.ramp_step(pat_ctrl_q[`RAMP_STEP_HI:`RAMP_STEP_LO]),
		.fixed_word0_ch1(word0),
		.fixed_word1_ch1(word1),
		.advance(start),
		.pattern_word(pattern_word)
	);

	// Source selection before the LSB fold
	assign ch1_src = pat_ctrl_q[`PAT_EN_BIT] ? pattern_word :
		conv_data_ch1; // [RULE_06]

	lsb_xor #(.WIDTH(24)) u_xor1
	(
		.enable(lane_cfg_q[`XOR_EN_BIT]),
		.din(ch1_src),
		.dout(ch1_x)
	);

	lsb_xor #(.WIDTH(24)) u_xor2
	(
		.enable(lane_cfg_q[`XOR_EN_BIT]),
		.din(conv_data_ch2),
		.dout(ch2_x)
	);

	// Short words keep the upper 20 bits, MSB first
	assign ch1_j = (bits_sel == `BITS_SHORT) ? {ch1_x[23:4], 4'h0} : ch1_x;
	assign ch2_j = (bits_sel == `BITS_SHORT) ? {ch2_x[23:4], 4'h0} : ch2_x;
	assign ch1_t = ch1_j;
	assign ch2_t = ch2_j;

	// Samples arriving mid-frame are dropped, not queued
	assign start = conv_valid & (cnt_q == 6'h00);

	always @*
	begin
		lanes_sel = lane_cfg_q[`LANE_CODE_HI:`LANE_CODE_LO]; // [RULE_13]
		case (lanes_sel)
			`LANES_TWO_20:
			begin
				bits_sel = `BITS_SHORT; // [RULE_02]
				one_sel = 1'b0;
			end
			`LANES_ONE_20:
			begin
				bits_sel = `BITS_SHORT; // [RULE_04]
				one_sel = 1'b1;
			end
			`LANES_ONE_24:
			begin
				bits_sel = `BITS_LONG; // [RULE_05]
				one_sel = 1'b1;
			end
			default:
			begin
				// Undefined codes behave as the reset code
				bits_sel = `BITS_LONG; // [RULE_03]
				one_sel = 1'b0;
			end
		endcase
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sh1_q <= 48'h000000000000;
			sh2_q <= 48'h000000000000;
			cnt_q <= 6'h00;
			len_q <= `BITS_LONG;
			one_lane_q <= 1'b0;
			serial_out_first <= 1'b0;
			serial_out_second <= 1'b0;
		end
		else
		begin
			if (start)
			begin
				len_q <= bits_sel;
				one_lane_q <= one_sel;
				if (one_sel)
				begin
					// Both channels back to back on the first lane
					sh1_q <= {ch1_t[22:0], ch2_t, 1'b0} |
						((bits_sel == `BITS_SHORT) ?
						{20'h00000, ch2_t[23:4], 8'h00} :
						48'h000000000000) &
						48'h00000fffff00; // [RULE_04]
					if (bits_sel == `BITS_SHORT)
						sh1_q <= {ch1_t[22:4], ch2_t[23:4], 9'h000};
					cnt_q <= (bits_sel << 1) - 6'h01;
					serial_out_first <= ch1_t[23];
					serial_out_second <= 1'b0;
				end
				else
				begin
					sh1_q <= {ch1_t[22:0], 25'h0000000};
					sh2_q <= {ch2_t[22:0], 25'h0000000};
					cnt_q <= bits_sel - 6'h01;
					serial_out_first <= ch1_t[23];
					serial_out_second <= ch2_t[23];
				end
			end
			else if (cnt_q != 6'h00)
			begin
				serial_out_first <= sh1_q[47];
				serial_out_second <= one_lane_q ? 1'b0 : sh2_q[47];
				sh1_q <= {sh1_q[46:0], 1'b0};
				sh2_q <= {sh2_q[46:0], 1'b0};
				cnt_q <= cnt_q - 6'h01;
			end
			else
			begin
				serial_out_first <= 1'b0;
				serial_out_second <= 1'b0;
			end
		end
	end

	// Frame markers; busy drops the cycle after the last bit
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			frame_sync <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			frame_sync <= start;
			if (start)
				busy <= 1'b1;
			else if (cnt_q == 6'h00)
				busy <= 1'b0;
		end
	end

	// Set wins over a clearing read in the same cycle
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			overrun_q <= 1'b0;
		else if (conv_valid & (cnt_q != 6'h00))
			overrun_q <= 1'b1;
		else if (rd_status)
			overrun_q <= 1'b0;
	end

	// Register slave: one wait cycle, then answer
	always @*
	begin
		rd_d = 32'h00000000;
		hit = 1'b1;
		if (reg_idx == `REG_LANE_CFG)
			rd_d[15:0] = lane_cfg_q;
		else if (reg_idx == `REG_PAT_CTRL)
			rd_d[15:0] = pat_ctrl_q;
		else if (reg_idx == `REG_PAT0_LOW)
			rd_d[15:0] = pat0_low_q;
		else if (reg_idx == `REG_PAT_SPLIT)
			rd_d[15:0] = pat_split_q;
		else if (reg_idx == `REG_PAT1_HIGH)
			rd_d[15:0] = pat1_high_q;
		else if (reg_idx == `REG_STATUS)
			rd_d[15:0] = {8'h00, len_q[5:0], overrun_q, one_lane_q};
		else
			hit = 1'b0;
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			ack_q <= 1'b0;
			avs_waitrequest <= 1'b1;
		end
		else
		begin
			// ack_q stops a held request being taken twice
			ack_q <= access;
			avs_waitrequest <= ~access;
		end
	end

	// Read data holds until the next read
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			avs_readdata <= 32'h00000000;
		else if (access & avs_read)
			avs_readdata <= hit ? rd_d : 32'h00000000;
	end

	// Reserved bits are stored as written
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			lane_cfg_q <= `LANE_CFG_RST; // [RULE_13]
		else if (wr_lane)
			lane_cfg_q <= (lane_cfg_q & ~wmask) |
				(avs_writedata[15:0] & wmask);
	end

	// A new select restarts the pattern sequence
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			pat_ctrl_q <= `PAT_CTRL_RST;
		else if (wr_ctrl)
			pat_ctrl_q <= (pat_ctrl_q & ~wmask) |
				(avs_writedata[15:0] & wmask);
	end

	// Pattern words are read live, so a write shows next frame
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			pat0_low_q <= `PAT_WORD_RST;
		else if (wr_p0lo)
			pat0_low_q <= (pat0_low_q & ~wmask) |
				(avs_writedata[15:0] & wmask);
	end

	// Shared between both pattern words
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			pat_split_q <= `PAT_WORD_RST;
		else if (wr_split)
			pat_split_q <= (pat_split_q & ~wmask) |
				(avs_writedata[15:0] & wmask);
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
			pat1_high_q <= `PAT_WORD_RST;
		else if (wr_p1hi)
			pat1_high_q <= (pat1_high_q & ~wmask) |
				(avs_writedata[15:0] & wmask);
	end

endmodule // adc_output_format

// File: design/fmt_regs.vh
`ifndef FMT_REGS_VH
`define FMT_REGS_VH
// Register indices; byte address is four times the index
`define REG_LANE_CFG 6'h12
`define REG_PAT_CTRL 6'h13
`define REG_PAT0_LOW 6'h14
`define REG_PAT_SPLIT 6'h15
`define REG_PAT1_HIGH 6'h16
`define REG_STATUS 6'h17
// Field positions
`define LANE_CODE_HI 2
`define LANE_CODE_LO 0
`define XOR_EN_BIT 3
`define PAT_EN_BIT 1
`define PAT_SEL_HI 3
`define PAT_SEL_LO 2
`define RAMP_STEP_HI 7
`define RAMP_STEP_LO 4
// Reset values
`define LANE_CFG_RST 16'h0002
`define PAT_CTRL_RST 16'h0000
`define PAT_WORD_RST 16'h0000
// Lane codes
`define LANES_TWO_20 3'h0
`define LANES_TWO_24 3'h2
`define LANES_ONE_20 3'h5
`define LANES_ONE_24 3'h7
// Pattern select codes
`define PSEL_FIXED0 2'h0
`define PSEL_FIXED1 2'h1
`define PSEL_RAMP 2'h2
`define PSEL_ALT 2'h3
// Bits per channel
`define BITS_SHORT 6'h14
`define BITS_LONG 6'h18
`endif

// File: design/pattern_gen.v
`timescale 1ns/1ps
`include "fmt_regs.vh"
module pattern_gen
(
	input wire ref_clk,
	input wire sys_rst,
	input wire [1:0] pattern_select_ch1,
	input wire [3:0] ramp_step,
	input wire [23:0] fixed_word0_ch1,
	input wire [23:0] fixed_word1_ch1,
	input wire advance,
	output reg [23:0] pattern_word
);
	reg [23:0] ramp_q;
	reg [23:0] ramp_d;
	reg alt_q;
	reg alt_d;
	reg [1:0] sel_q;
	always @*
	begin
		ramp_d = ramp_q;
		alt_d = alt_q;
		if (pattern_select_ch1 != sel_q)
		begin
			ramp_d = 24'h000000; // [RULE_15]
			alt_d = 1'b0; // [RULE_16]
		end
		else if (advance)
		begin
			// Wraps modulo 2^24 by width
			ramp_d = ramp_q + {20'h00000, ramp_step} + 24'h000001; // [RULE_10]
			alt_d = ~alt_q; // [RULE_16]
		end
	end
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			ramp_q <= 24'h000000;
			alt_q <= 1'b0;
			sel_q <= `PSEL_FIXED0;
		end
		else
		begin
			ramp_q <= ramp_d;
			alt_q <= alt_d;
			sel_q <= pattern_select_ch1;
		end
	end
	always @*
	begin
		case (pattern_select_ch1)
			`PSEL_RAMP: pattern_word = ramp_q; // [RULE_08]
			`PSEL_ALT: pattern_word = alt_q ? fixed_word1_ch1 :
				fixed_word0_ch1; // [RULE_09]
			default: pattern_word = fixed_word0_ch1; // [RULE_07]
		endcase
	end
endmodule // pattern_gen

// File: design/lsb_xor.v
`timescale 1ns/1ps
module lsb_xor
#(
	parameter WIDTH = 24
)
(
	input wire enable,
	input wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			assign dout[i] = din[i] ^ (enable & din[0]); // [RULE_01]
		end
	endgenerate
endmodule // lsb_xor

// File: testbench/out_chk.sv
`timescale 1ns/1ps
module out_chk
(
	input wire ref_clk,
	input wire sys_rst,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire conv_valid,
	input wire serial_out_first,
	input wire serial_out_second,
	input wire frame_sync,
	input wire busy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire req = avs_read | avs_write;
	sequence s_answer;
		avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
	endsequence
	// Shortest frame is 20 bits, so 8 busy cycles always hold
	sequence s_frame;
		frame_sync && busy ##1 (!frame_sync && busy) [*7];
	endsequence
	a_bus_answer: assert property (
		$rose(req) |-> s_answer)
		else $error("bus answer not after one wait cycle");
	a_wait_idle: assert property (
		!req |-> avs_waitrequest)
		else $error("waitrequest low without request");
	a_wait_single: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_rd_upper: assert property (
		!avs_waitrequest |-> !avs_readdata[31:16])
		else $error("read data upper half not zero");
	a_frame_start: assert property (
		conv_valid && !busy |=> s_frame)
		else $error("frame did not start after sample");
	a_busy_rise: assert property ($rose(busy) |-> frame_sync)
		else $error("busy rose without frame sync");
	a_sync_busy: assert property (frame_sync |-> busy)
		else $error("frame sync outside busy");
	a_lanes_idle: assert property (
		!busy |-> !serial_out_first && !serial_out_second)
		else $error("lane active while idle");
endmodule // out_chk

bind adc_output_format out_chk out_chk_i (.*);

// File: testbench/lane_capture.sv
`timescale 1ns/1ps
module lane_capture
(
	input wire ref_clk,
	input wire frame_sync,
	input wire serial_out_first,
	input wire serial_out_second,
	input wire [5:0] nb,
	output reg [47:0] w1,
	output reg [23:0] w2
);
	reg [5:0] cnt_q = 6'h3f;
	// Takes MSB first; stops at nb so idle zeros never shift in
	always @(posedge ref_clk)
	begin
		if (frame_sync)
		begin
			cnt_q <= 6'h1;
			w1 <= {47'h0, serial_out_first};
			w2 <= {23'h0, serial_out_second};
		end
		else if (cnt_q < nb)
		begin
			cnt_q <= cnt_q + 6'h1;
			w1 <= {w1[46:0], serial_out_first};
			w2 <= {w2[22:0], serial_out_second};
		end
	end
endmodule // lane_capture

// File: testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
	reg ref_clk = 1'h0;
	reg sys_rst = 1'h1;
	reg [7:0] avs_address = 8'h0;
	reg avs_read = 1'h0;
	reg avs_write = 1'h0;
	reg [31:0] avs_writedata = 32'h0;
	reg [3:0] avs_byteenable = 4'hf;
	reg [23:0] conv_data_ch1 = 24'h0;
	reg [23:0] conv_data_ch2 = 24'h0;
	reg conv_valid = 1'h0;
	reg [5:0] nb = 6'h18;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, serial_out_first, serial_out_second;
	wire frame_sync, busy;
	wire [47:0] w1;
	wire [23:0] w2;
	reg [15:0] rd;
	reg [47:0] ex;
	integer errors = 0, checked = 0, cyc = 0, i;
	always #50 ref_clk = ~ref_clk;
	adc_output_format adc_output_format_i (.*);
	lane_capture lane_capture_i (.*);
	task close_out;
	begin
		$display("Comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	task bus(input [0:0] wr, input [7:0] idx, input [15:0] wd);
	begin
		avs_address <= {idx[5:0], 2'h0};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {16'h0, wd};
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'h0)
			@(posedge ref_clk);
		rd = avs_readdata[15:0];
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge ref_clk);
	end
	endtask
	task chk_rd(input [7:0] idx, input [15:0] e);
	begin
		bus(1'h0, idx, 16'h0);
		`CHK(rd, e)
	end
	endtask
	// a drives the first channel, e1 is what must come out for it
	task smp(input [5:0] n, input [0:0] one, input [23:0] a, e1, b);
	begin
		nb <= one ? n * 6'h2 : n;
		conv_data_ch1 <= a;
		conv_data_ch2 <= b;
		conv_valid <= 1'h1;
		@(posedge ref_clk);
		conv_valid <= 1'h0;
		while (busy !== 1'h1)
			@(posedge ref_clk);
		while (busy !== 1'h0)
			@(posedge ref_clk);
		ex = e1 >> (24 - n);
		if (one)
			ex = (ex << n) | (b >> (24 - n));
		`CHK(w1, ex)
		`CHK(w2, one ? 24'h0 : b >> (24 - n))
	end
	endtask
	initial
	begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'h0;
		@(posedge ref_clk);
		chk_rd(8'h12, 16'h0002);
		for (i = 8'h13; i < 8'h17; i++)
			chk_rd(i[7:0], 16'h0);
		// Status shows 24 bits per channel after reset
		chk_rd(8'h17, 16'h0060);
		chk_rd(8'h1f, 16'h0);
		$display("Test reset values done");
		for (i = 0; i < 4; i++)
		begin
			bus(1'h1, 8'h12, {13'h0, i[1], i[0], i[1]});
			smp(i[0] ? 6'h18 : 6'h14, i[1], 24'hc3a5e1, 24'hc3a5e1,
				24'h13579a);
		end
		chk_rd(8'h12, 16'h0007);
		bus(1'h1, 8'h12, 16'h000a);
		smp(6'h18, 1'h0, 24'h123457, 24'hedcba8,
			24'h13579a);
		bus(1'h1, 8'h12, 16'h0002);
		// Second sample lands mid-frame: dropped and flagged
		conv_valid <= 1'h1;
		repeat (2) @(posedge ref_clk);
		conv_valid <= 1'h0;
		while (busy !== 1'h0)
			@(posedge ref_clk);
		chk_rd(8'h17, 16'h0062);
		chk_rd(8'h17, 16'h0060);
		$display("Test lanes and toggle done");
		bus(1'h1, 8'h14, 16'h1234);
		bus(1'h1, 8'h15, 16'hcd56);
		bus(1'h1, 8'h16, 16'h89ab);
		chk_rd(8'h15, 16'hcd56);
		for (i = 0; i < 2; i++)
		begin
			bus(1'h1, 8'h13, {12'h0, i[1:0], 2'h2});
			smp(6'h18, 1'h0, 24'h0f0f0f, 24'h561234,
				24'h13579a);
		end
		bus(1'h1, 8'h13, 16'h000e);
		for (i = 0; i < 3; i++)
			smp(6'h18, 1'h0, 24'h0f0f0f, i[0] ? 24'h89abcd : 24'h561234,
				24'h13579a);
		bus(1'h1, 8'h13, 16'h003a);
		for (i = 0; i < 3; i++)
			smp(6'h18, 1'h0, 24'h0f0f0f, {i[21:0], 2'h0},
				24'h13579a);
		bus(1'h1, 8'h13, 16'h000c);
		smp(6'h18, 1'h0, 24'h0f0f0f, 24'h0f0f0f,
			24'h13579a);
		$display("Test patterns done");
		close_out;
	end
	// About 500 cycles expected; ceiling leaves wide margin
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			errors++;
			close_out;
		end
	end
endmodule // testbench
